// File: rtl/endec_pkg.sv
// Functional notes
// RQ1: With the mode input low, each transmit pulse becomes a short IR pulse.
// RQ2: In data mode each IR receive pulse is stretched to one bit time.
// RQ3: The transceiver sends active-low receive pulses of at least 1.63 us.
// RQ4: With the mode input high, serial characters are control words.
// RQ5: A new control word takes effect only when the mode input falls.
// RQ6: Reset clears every internal configuration register.
// RQ7: Reset loads 9600 bit/s and the fixed 1.627 us pulse width.
// RQ8: The host holds reset at start-up and for at least 1 us each time; the bench holds it only 20 cycles (under 1 us) at start-up.
// RQ9: The oscillator is stopped while reset is asserted.
// RQ10: The shutdown output is the inverse of the reset input.
// RQ11: Two active-low user outputs follow the two user bits of the config.
// RQ12: An active-low transmit activity output drives an LED.
// RQ13: An active-low receive activity output drives an LED.
// RQ14: Only the low seven bits of a control character count, sent as 8N1.
// RQ15: Bit 4 picks 1.627 us or 3/16 bit pulses; bits 5 and 6 are user bits.
// RQ16: The low four bits pick the rate, codes 0 to 5 as 115.2k down to 12.8k.
// RQ17: Timing comes from dividing the clock; one IR pulse per zero bit.
package endec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned CLK_MHZ  = 40;
  localparam int unsigned PULSE_NS = 1627;
  localparam logic [15:0] PULSE_CYC =
    16'((PULSE_NS * CLK_MHZ + 999) / 1000);

  // Bit periods of the fast rate codes 0 to 5
  localparam logic [15:0] BIT_CYC_115K2 = 16'(CLK_HZ / 115200);
  localparam logic [15:0] BIT_CYC_57K6  = 16'(CLK_HZ / 57600);
  localparam logic [15:0] BIT_CYC_38K4  = 16'(CLK_HZ / 38400);
  localparam logic [15:0] BIT_CYC_19K2  = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BIT_CYC_14K4  = 16'(CLK_HZ / 14400);
  localparam logic [15:0] BIT_CYC_12K8  = 16'(CLK_HZ / 12800);

  // Slow rate codes 6 to 12, entry 0 is 9600 bit/s
  localparam logic [6:0][15:0] SLOW_BIT_CYC_DEF = {
    16'(CLK_HZ / 1200), 16'(CLK_HZ / 1800), 16'(CLK_HZ / 2400),
    16'(CLK_HZ / 3600), 16'(CLK_HZ / 4800), 16'(CLK_HZ / 7200),
    16'(CLK_HZ / 9600)};
  localparam logic [3:0] RATE_SLOW_FIRST = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Control word
  typedef struct packed {
    logic       user_rear;   // bit 6
    logic       user_front;  // bit 5
    logic       width_fixed; // bit 4
    logic [3:0] rate_select_code;
  } cfg_t;

  localparam int unsigned CFG_BITS       = 7;
  localparam int unsigned CHAR_BITS      = 8;
  localparam int unsigned CFG_RATE_LSB   = 0;
  localparam int unsigned CFG_WIDTH_BIT  = 4;
  localparam int unsigned CFG_FRONT_BIT  = 5;
  localparam int unsigned CFG_REAR_BIT   = 6;
  localparam cfg_t        CFG_RESET      = cfg_t'(7'h16);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon register map, byte addresses
  localparam logic [3:0] ADDR_ACTIVE  = 4'h0;
  localparam logic [3:0] ADDR_PENDING = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam int unsigned STAT_MODE_BIT = 0;
  localparam int unsigned STAT_TX_BIT   = 1;
  localparam int unsigned STAT_RX_BIT   = 2;

endpackage

// File: rtl/pulse_timer.sv
`timescale 1ns/10ps
module pulse_timer
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Start and length
  input  wire logic        trig,
  input  wire logic [15:0] len,
  // Pulse
  output logic             active
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        active;
  } pt_state_t;

  pt_state_t st_ff;
  pt_state_t nxt_st;

  // Restartable one-shot of len cycles
  always_comb
  begin
    nxt_st = st_ff;
    if (trig)
    begin
      nxt_st.active = 1'b1;
      nxt_st.cnt    = (len == 16'h0) ? 16'h0 : len - 16'h1;
    end
    else if (st_ff.active)
    begin
      if (st_ff.cnt == 16'h0)
        nxt_st.active = 1'b0;
      else
        nxt_st.cnt = st_ff.cnt - 16'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign active = st_ff.active;

endmodule

// File: rtl/char_rx.sv
`timescale 1ns/10ps
module char_rx
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Line and timing
  input  wire logic        enable,
  input  wire logic        rx,
  input  wire logic [15:0] bit_cyc,
  // Received character
  output logic             char_valid,
  output logic [7:0]       char_data
);

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_fsm_t;

  typedef struct packed {
    rx_fsm_t     state;
    logic [15:0] cnt;
    logic [2:0]  bits;
    logic [7:0]  shift;
    logic        valid;
  } rx_state_t;

  rx_state_t st_ff;
  rx_state_t nxt_st;

  // 8N1 receiver sampling mid-bit
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.valid = 1'b0;
    if (!enable)
    begin
      nxt_st.state = RX_IDLE;
      nxt_st.cnt   = 16'h0;
    end
    else
    begin
      unique case (st_ff.state)
        RX_IDLE:
          if (!rx)
          begin
            nxt_st.state = RX_START;
            nxt_st.cnt   = bit_cyc >> 1;
          end
        RX_START:
          if (st_ff.cnt != 16'h0)
            nxt_st.cnt = st_ff.cnt - 16'h1;
          else if (!rx)
          begin
            nxt_st.state = RX_DATA;
            nxt_st.cnt   = bit_cyc - 16'h1;
            nxt_st.bits  = 3'h0;
          end
          else
            nxt_st.state = RX_IDLE;      // Glitch, not a start bit
        RX_DATA:
          if (st_ff.cnt != 16'h0)
            nxt_st.cnt = st_ff.cnt - 16'h1;
          else
          begin
            nxt_st.shift = {rx, st_ff.shift[7:1]};
            nxt_st.cnt   = bit_cyc - 16'h1;
            if (st_ff.bits == 3'h7)
              nxt_st.state = RX_STOP;
            else
              nxt_st.bits = st_ff.bits + 3'h1;
          end
        RX_STOP:
          if (st_ff.cnt != 16'h0)
            nxt_st.cnt = st_ff.cnt - 16'h1;
          else
          begin
            nxt_st.valid = rx;             // Framing error drops it
            nxt_st.state = RX_IDLE;
          end
        default:
          nxt_st.state = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_ff <= '{state: RX_IDLE, cnt: 16'h0, bits: 3'h0, shift: 8'h0,
                 valid: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign char_valid = st_ff.valid;
  assign char_data  = st_ff.shift;

endmodule

// File: rtl/sir_infrared_pulse_endec.sv
`timescale 1ns/10ps
module sir_infrared_pulse_endec
#(
  parameter logic [6:0][15:0] SLOW_BIT_CYC = endec_pkg::SLOW_BIT_CYC_DEF
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Host serial side
  input  wire logic        serial_tx_in,
  output logic             serial_rx_out,
  input  wire logic        config_mode_select,
  // Infrared transceiver side
  output logic             ir_tx_pulse_out,
  input  wire logic        ir_rx_pulse_in_n,
  output logic             transceiver_shutdown_n,
  // Oscillator run, user and indicator outputs
  output logic             osc_run,
  output logic             user_out_front_n,
  output logic             user_out_rear_n,
  output logic             tx_activity_indicator_n,
  output logic             rx_activity_indicator_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    endec_pkg::cfg_t active;
    endec_pkg::cfg_t pending;
    logic            mode_prev;
    logic            tx_prev;
    logic            rx_prev;
    logic [15:0]     tx_bit_cnt;
    logic            ir_tx;
    logic            ser_rx;
    logic            tx_led_n;
    logic            rx_led_n;
    logic            front_n;
    logic            rear_n;
    logic            sd_n;
    logic            osc;
    logic            waitreq;
    logic [31:0]     rdata;
  } top_state_t;

  localparam top_state_t ST_RESET = '{
    active:     endec_pkg::CFG_RESET,                      // see RQ7
    pending:    endec_pkg::CFG_RESET,
    mode_prev:  1'b0,
    tx_prev:    1'b1,
    rx_prev:    1'b1,
    tx_bit_cnt: 16'h0,
    ir_tx:      1'b0,
    ser_rx:     1'b1,
    tx_led_n:   1'b1,
    rx_led_n:   1'b1,
    front_n:    1'b1,
    rear_n:     1'b1,
    sd_n:       1'b0,
    osc:        1'b0,
    waitreq:    1'b1,
    rdata:      32'h0
  };

  top_state_t  st_ff;
  top_state_t  nxt_st;

  logic [15:0] bit_cyc;
  logic [15:0] pulse_len;
  logic [15:0] short_len;
  logic        data_mode;
  logic        tx_trig;
  logic        rx_trig;
  logic        tx_active;
  logic        rx_active;
  logic        char_valid;
  logic [7:0]  char_data;
  logic        bus_req;
  logic [31:0] rd_mux;

  assign data_mode = !config_mode_select;
  assign bus_req   = avs_read | avs_write;

  ////////////////////////////////////////////////////////////////////////////
  // Rate and pulse width

  // Bit period of the active rate code
  always_comb
  begin
    unique case (st_ff.active.rate_select_code)
      4'h0: bit_cyc = endec_pkg::BIT_CYC_115K2;      // see RQ16
      4'h1: bit_cyc = endec_pkg::BIT_CYC_57K6;       // see RQ16
      4'h2: bit_cyc = endec_pkg::BIT_CYC_38K4;
      4'h3: bit_cyc = endec_pkg::BIT_CYC_19K2;
      4'h4: bit_cyc = endec_pkg::BIT_CYC_14K4;
      4'h5: bit_cyc = endec_pkg::BIT_CYC_12K8;
      4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc:
        bit_cyc = SLOW_BIT_CYC[3'(st_ff.active.rate_select_code
                                  - endec_pkg::RATE_SLOW_FIRST)];
      default: bit_cyc = SLOW_BIT_CYC[0];
    endcase
  end

  // Fixed short pulse or three sixteenths of a bit
  assign short_len = 16'((18'(bit_cyc) * 18'h3) >> 4);
  assign pulse_len = st_ff.active.width_fixed ? endec_pkg::PULSE_CYC
                                              : short_len;   // see RQ15

  ////////////////////////////////////////////////////////////////////////////
  // Pulse timers and control character receiver

  // Shortened transmit pulse
  pulse_timer u_tx_pulse
  (
    .clock  (clock),
    .rstn   (rstn),
    .trig   (tx_trig),
    .len    (pulse_len),
    .active (tx_active)
  );

  // Received pulse stretched to one bit
  pulse_timer u_rx_stretch
  (
    .clock  (clock),
    .rstn   (rstn),
    .trig   (rx_trig),
    .len    (bit_cyc),
    .active (rx_active)
  );

  // Control characters, only in programming mode
  char_rx u_char_rx
  (
    .clock      (clock),
    .rstn       (rstn),
    .enable     (config_mode_select),                        // see RQ4
    .rx         (serial_tx_in),
    .bit_cyc    (bit_cyc),
    .char_valid (char_valid),
    .char_data  (char_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (avs_address)
      endec_pkg::ADDR_ACTIVE:  rd_mux = {25'h0, st_ff.active};
      endec_pkg::ADDR_PENDING: rd_mux = {25'h0, st_ff.pending};
      endec_pkg::ADDR_STATUS:
      begin
        rd_mux[endec_pkg::STAT_MODE_BIT] = config_mode_select;
        rd_mux[endec_pkg::STAT_TX_BIT]   = tx_active;
        rd_mux[endec_pkg::STAT_RX_BIT]   = rx_active;
      end
      default: rd_mux = 32'h0;                    // Unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_st  = st_ff;
    tx_trig = 1'b0;
    rx_trig = 1'b0;

    // Edge history of the serial and IR inputs
    nxt_st.tx_prev   = serial_tx_in;
    nxt_st.rx_prev   = ir_rx_pulse_in_n;
    nxt_st.mode_prev = config_mode_select;

    // One short IR pulse per zero bit, resynced on each fall
    if (data_mode)
    begin
      if (st_ff.tx_prev && !serial_tx_in)
      begin
        tx_trig           = 1'b1;                          // see RQ1
        nxt_st.tx_bit_cnt = bit_cyc - 16'h1;               // see RQ17
      end
      else if (!serial_tx_in && st_ff.tx_bit_cnt == 16'h0)
      begin
        tx_trig           = 1'b1;                          // see RQ17
        nxt_st.tx_bit_cnt = bit_cyc - 16'h1;
      end
      else if (st_ff.tx_bit_cnt != 16'h0)
        nxt_st.tx_bit_cnt = st_ff.tx_bit_cnt - 16'h1;
    end
    else
      nxt_st.tx_bit_cnt = 16'h0;

    // Falling edge of the active-low IR receive input
    if (data_mode && st_ff.rx_prev && !ir_rx_pulse_in_n)
      rx_trig = 1'b1;                                      // see RQ2

    // Bus write to the pending word, takes effect like a character
    if (avs_write && !st_ff.waitreq &&
        avs_address == endec_pkg::ADDR_PENDING)
      nxt_st.pending = endec_pkg::cfg_t'(avs_writedata[6:0]);

    // Control character keeps its low seven bits only
    if (config_mode_select && char_valid)
      nxt_st.pending = endec_pkg::cfg_t'(char_data[6:0]);  // see RQ14

    // Pending word becomes active when the mode input falls
    if (st_ff.mode_prev && !config_mode_select)
      nxt_st.active = st_ff.pending;                       // see RQ5

    // Data path outputs, idle outside data mode
    nxt_st.ir_tx    = data_mode & tx_active;               // see RQ1
    nxt_st.ser_rx   = !(data_mode & rx_active);            // see RQ2
    nxt_st.tx_led_n = !(data_mode & tx_active);            // see RQ12
    nxt_st.rx_led_n = !(data_mode & rx_active);            // see RQ13

    // User outputs follow the configuration that takes effect
    nxt_st.front_n = !nxt_st.active.user_front;            // see RQ11
    nxt_st.rear_n  = !nxt_st.active.user_rear;             // see RQ11

    // Leave shutdown and restart oscillator once reset is gone
    nxt_st.sd_n = 1'b1;                                    // see RQ10
    nxt_st.osc  = 1'b1;                                    // see RQ9

    // Avalon: one wait cycle, then one cycle with waitrequest low
    nxt_st.waitreq = 1'b1;
    if (bus_req && st_ff.waitreq)
    begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata   = rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset clears config and loads the default word
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_ff <= ST_RESET;                                   // see RQ6
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ir_tx_pulse_out         = st_ff.ir_tx;
  assign serial_rx_out           = st_ff.ser_rx;
  assign tx_activity_indicator_n = st_ff.tx_led_n;
  assign rx_activity_indicator_n = st_ff.rx_led_n;
  assign user_out_front_n        = st_ff.front_n;
  assign user_out_rear_n         = st_ff.rear_n;
  assign transceiver_shutdown_n  = st_ff.sd_n;             // see RQ10
  assign osc_run                 = st_ff.osc;              // see RQ9
  assign avs_readdata            = st_ff.rdata;
  assign avs_waitrequest         = st_ff.waitreq;

  // Default word 9600 bit/s and fixed pulse is in ST_RESET   see RQ7

endmodule

// File: sim/endec_sva.sv
`timescale 1ns/10ps
module endec_sva
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial, infrared and status lines
  input wire logic serial_tx_in,
  input wire logic serial_rx_out,
  input wire logic config_mode_select,
  input wire logic ir_tx_pulse_out,
  input wire logic ir_rx_pulse_in_n,
  input wire logic transceiver_shutdown_n,
  input wire logic osc_run,
  input wire logic user_out_front_n,
  input wire logic user_out_rear_n,
  input wire logic tx_activity_indicator_n,
  input wire logic rx_activity_indicator_n
);
  localparam int MIN_BIT = 347;
  logic [15:0] low_cnt_ff;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////
  // Cycles the serial receive line has stood low
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      low_cnt_ff <= 16'h0;
    else
      low_cnt_ff <= serial_rx_out ? 16'h0 : low_cnt_ff + 16'h1;

  // Reset and oscillator outputs
  a_shutdown_high:
    assert property ($past(rstn) |-> transceiver_shutdown_n)
    else $error("shutdown output low out of reset");
  a_osc_running:
    assert property (rstn |=> osc_run)
    else $error("oscillator not running out of reset");

  // Data mode transmit
  a_tx_answer:
    assert property ($fell(serial_tx_in) && !config_mode_select
      |-> ##[1:3] ir_tx_pulse_out)
    else $error("no infrared pulse after a low bit");
  a_tx_silent_prog:
    assert property (config_mode_select && $past(config_mode_select, 2)
      |-> !$rose(ir_tx_pulse_out))
    else $error("infrared pulse in programming mode");
  a_tx_led_on:
    assert property ($rose(ir_tx_pulse_out)
      |-> ##[0:1] !tx_activity_indicator_n)
    else $error("transmit indicator not lit");

  // Data mode receive
  a_rx_answer:
    assert property ($fell(ir_rx_pulse_in_n) && !config_mode_select
      |-> ##[1:3] !serial_rx_out)
    else $error("no stretched bit after a receive pulse");
  a_rx_stretch_len:
    assert property ($rose(serial_rx_out) |-> low_cnt_ff >= MIN_BIT)
    else $error("stretched bit shorter than a bit time");
  a_rx_led_on:
    assert property ($fell(serial_rx_out)
      |-> ##[0:1] !rx_activity_indicator_n)
    else $error("receive indicator not lit");

  // User outputs only move once programming ends
  a_user_static:
    assert property ($changed(user_out_front_n) || $changed(user_out_rear_n)
      |-> !config_mode_select)
    else $error("user output moved in programming mode");

  c_tx_pulse: cover property ($fell(ir_tx_pulse_out));
  c_rx_stretch: cover property ($rose(serial_rx_out));
  c_mode_fall: cover property ($fell(config_mode_select));
endmodule

bind sir_infrared_pulse_endec endec_sva endec_sva_inst
(
  .clock                  (clock),
  .rstn                   (rstn),
  .serial_tx_in           (serial_tx_in),
  .serial_rx_out          (serial_rx_out),
  .config_mode_select     (config_mode_select),
  .ir_tx_pulse_out        (ir_tx_pulse_out),
  .ir_rx_pulse_in_n       (ir_rx_pulse_in_n),
  .transceiver_shutdown_n (transceiver_shutdown_n),
  .osc_run                (osc_run),
  .user_out_front_n       (user_out_front_n),
  .user_out_rear_n        (user_out_rear_n),
  .tx_activity_indicator_n(tx_activity_indicator_n),
  .rx_activity_indicator_n(rx_activity_indicator_n)
);

// File: sim/ir_host_model.sv
`timescale 1ns/10ps
module ir_host_model
(
  // Clock
  input  wire logic clock,
  // Host transmit line and transceiver receive line
  output logic      serial_tx_in,
  output logic      ir_rx_pulse_in_n
);
  ////////////////////////////////////////////////////////////
  // Both lines idle high from time zero
  initial
  begin
    serial_tx_in = 1'b1;
    ir_rx_pulse_in_n = 1'b1;
  end

  // Drives the host line to one level for n cycles
  task automatic hold_tx(input logic lvl, input int n);
    @(posedge clock);
    serial_tx_in <= lvl;
    repeat (n - 1) @(posedge clock);
  endtask

  // One 8N1 character, least significant bit first
  task automatic send_char(input logic [7:0] c, input int n);
    hold_tx(1'b0, n);
    for (int i = 0; i < 8; i++)
      hold_tx(c[i], n);
    hold_tx(1'b1, 2 * n);
  endtask

  // One zero bit in data mode, then idle
  task automatic tx_zero(input int n);
    hold_tx(1'b0, n);
    hold_tx(1'b1, 1);
  endtask

  // Active-low receive pulse, never under 66 cycles
  task automatic ir_pulse(input int n);
    @(posedge clock);
    ir_rx_pulse_in_n <= 1'b0;
    repeat ((n < 66) ? 66 : n) @(posedge clock);
    ir_rx_pulse_in_n <= 1'b1;
  endtask
endmodule

// File: sim/sir_infrared_pulse_endec_tb.sv
`timescale 1ns/10ps
module sir_infrared_pulse_endec_tb;
  // Bench drives
  logic        clock;
  logic        rstn;
  logic        config_mode_select;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  // Design and partner outputs
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_tx_in, ir_rx_pulse_in_n, serial_rx_out;
  logic        ir_tx_pulse_out, transceiver_shutdown_n, osc_run;
  logic        user_out_front_n, user_out_rear_n;
  logic        tx_activity_indicator_n, rx_activity_indicator_n;
  // Bookkeeping
  int          err_count;
  int          n_checks;
  int          cyc;
  logic [6:0]  cur;
  logic [31:0] q;

  ir_host_model ir_host_model_inst
  (
    .clock(clock),
    .serial_tx_in(serial_tx_in),
    .ir_rx_pulse_in_n(ir_rx_pulse_in_n)
  );

  sir_infrared_pulse_endec
  #(
    .SLOW_BIT_CYC({16'h01c0, 16'h01b8, 16'h01b0, 16'h01a8,
                   16'h01a0, 16'h0198, 16'h0190})
  )
  sir_infrared_pulse_endec_inst
  (
    .clock(clock),
    .rstn(rstn),
    .serial_tx_in(serial_tx_in),
    .serial_rx_out(serial_rx_out),
    .config_mode_select(config_mode_select),
    .ir_tx_pulse_out(ir_tx_pulse_out),
    .ir_rx_pulse_in_n(ir_rx_pulse_in_n),
    .transceiver_shutdown_n(transceiver_shutdown_n),
    .osc_run(osc_run),
    .user_out_front_n(user_out_front_n),
    .user_out_rear_n(user_out_rear_n),
    .tx_activity_indicator_n(tx_activity_indicator_n),
    .rx_activity_indicator_n(rx_activity_indicator_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #12.5 clock = ~clock;

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      err_count++;
      $display("BAD timeout expected done seen hang");
      wrap_up();
    end
  end

  // Compares one value
  task automatic check(input string what, input logic [31:0] want,
                       input logic [31:0] got);
    n_checks++;
    if (got !== want)
    begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, want, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Bit period for a rate code
  function automatic int exp_bit(input logic [3:0] code);
    case (code)
      4'h0: return 347;
      4'h1: return 694;
      4'h2: return 1041;
      4'h3: return 2083;
      4'h4: return 2777;
      4'h5: return 3125;
      default: return (code > 4'hc) ? 400 : 400 + 8 * (code - 6);
    endcase
  endfunction

  // Infrared pulse length for a control word
  function automatic int exp_pulse(input logic [6:0] w);
    return w[4] ? 66 : exp_bit(w[3:0]) * 3 / 16;
  endfunction

  // Active stretch (sel) or active transmit pulse
  function automatic logic probe(input logic sel);
    return sel ? serial_rx_out === 1'b0 : ir_tx_pulse_out === 1'b1;
  endfunction

  // Waits for the line to go active and counts its cycles
  task automatic measure(input logic sel, output int n);
    int t;
    t = 0;
    n = 0;
    while (!probe(sel) && t < 20)
    begin
      @(posedge clock);
      t++;
    end
    while (probe(sel) && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
  endtask

  // Loads a control word, then checks its effect
  task automatic apply(input logic [7:0] c, input logic by_char);
    int n;
    logic [6:0] old;
    old = cur;
    config_mode_select <= 1'b1;
    if (by_char)
      ir_host_model_inst.send_char(c, exp_bit(old[3:0]));
    else
      bus(1'b1, endec_pkg::ADDR_PENDING, {24'h0, c});
    bus(1'b0, endec_pkg::ADDR_PENDING, 32'h0);
    check("pending", {25'h0, c[6:0]}, q);
    bus(1'b0, endec_pkg::ADDR_STATUS, 32'h0);
    check("status", 32'h1, q);
    bus(1'b0, endec_pkg::ADDR_ACTIVE, 32'h0);
    check("active held", {25'h0, old}, q);
    config_mode_select <= 1'b0;
    repeat (3) @(posedge clock);
    cur = c[6:0];
    bus(1'b0, endec_pkg::ADDR_ACTIVE, 32'h0);
    check("active", {25'h0, cur}, q);
    check("front", {31'h0, ~cur[5]}, 32'(user_out_front_n));
    check("rear", {31'h0, ~cur[6]}, 32'(user_out_rear_n));
    fork
      ir_host_model_inst.ir_pulse(66);
      measure(1'b1, n);
    join
    check("stretch", exp_bit(cur[3:0]), n);
    fork
      ir_host_model_inst.tx_zero(exp_bit(cur[3:0]));
      measure(1'b0, n);
    join
    check("pulse", exp_pulse(cur), n);
    $display("test word %0h done", c);
  endtask

  // Prints counts and verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clock = 1'b0;
    rstn = 1'b0;
    config_mode_select = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cur = 7'h16;
    void'($urandom(59718));
    repeat (20) @(posedge clock);
    check("shutdown", 32'h0, 32'(transceiver_shutdown_n));
    check("osc", 32'h0, 32'(osc_run));
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("shutdown", 32'h1, 32'(transceiver_shutdown_n));
    check("osc", 32'h1, 32'(osc_run));
    bus(1'b0, endec_pkg::ADDR_ACTIVE, 32'h0);
    check("reset word", 32'h16, q);
    $display("test reset done");
    apply({1'b1, 2'($urandom), 5'h06}, 1'b1);
    for (int k = 0; k < 6; k++)
      apply(8'({$urandom, 4'(k)}), 1'b0);
    apply(8'h1c, 1'b0);
    apply(8'h7d, 1'b0);
    bus(1'b1, endec_pkg::ADDR_ACTIVE, 32'h7f);
    bus(1'b0, endec_pkg::ADDR_ACTIVE, 32'h0);
    check("read only", {25'h0, cur}, q);
    bus(1'b0, 4'hc, 32'h0);
    check("unmapped", 32'h0, q);
    $display("test access kinds done");
    rstn <= 1'b0;
    repeat (40) @(posedge clock);
    check("shutdown", 32'h0, 32'(transceiver_shutdown_n));
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    bus(1'b0, endec_pkg::ADDR_ACTIVE, 32'h0);
    check("cleared", 32'h16, q);
    check("front", 32'h1, 32'(user_out_front_n));
    $display("test second reset done");
    wrap_up();
  end
endmodule
